/* File: inc/io_ports_pkg.sv */
// Package holding offsets, field positions, reset values and encodings of the I/O port block.
package io_ports_pkg;

  // ----------------------------------------------------------------
  // Register offsets on the local I/O bus
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_COMMAND_STATUS = 8'h00;
  localparam logic [7:0] OFS_OPTION_SWITCH_INPUT = 8'h01;
  localparam logic [7:0] OFS_UNIT_SELECT_LED_PORT = 8'h02;
  localparam logic [7:0] OFS_DRIVE_CONTROL_PORT = 8'h03;
  localparam logic [7:0] OFS_TIMER_HIGH_MODE = 8'h04;
  localparam logic [7:0] OFS_TIMER_LOW_COUNT = 8'h05;
  localparam logic [7:0] LED_ADDR_FIRST = 8'h20;
  localparam logic [7:0] LED_ADDR_LAST = 8'h2f;

  // ----------------------------------------------------------------
  // Command register fields
  // ----------------------------------------------------------------
  localparam int CMD_DIR_A_BIT = 0;
  localparam int CMD_DIR_B_BIT = 1;
  localparam int CMD_DRIVE_CONTROL_PORT_LSB = 2;
  localparam int CMD_IEN_A_BIT = 4;
  localparam int CMD_IEN_B_BIT = 5;
  localparam int CMD_TIMER_LSB = 6;

  // Status register fields.
  localparam int STS_A_LSB = 0;
  localparam int STS_B_LSB = 3;
  localparam int STS_TIMER_BIT = 6;

  // Drive-control port fields and the mask of implemented bits.
  localparam int DRV_WRITE_CURRENT_BIT = 0;
  localparam int DRV_MASTER_WRITE_GATE_BIT = 1;
  localparam int DRV_HEAD_LOAD_CTL_BIT = 2;
  localparam int DRV_STEP_DIRECTION_BIT = 3;
  localparam int DRV_SIDE_SELECT_BIT = 4;
  localparam int DRV_RW_SEQUENCER_RESET_BIT = 5;
  localparam logic [7:0] DRV_IMPL_MASK = 8'h3f;

  // Timer high register fields.
  localparam int TMR_HIGH_COUNT_BITS = 6;
  localparam int TMR_MODE_LSB = 6;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] LED_LATCH_RESET = 8'h00;
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [13:0] TIMER_LENGTH_RESET = 14'h0000;
  localparam logic [3:0] TIMER_TICK_LAST = 4'hf;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TCMD_NOP = 2'b00,
    TCMD_STOP = 2'b01,
    TCMD_STOP_AFTER_TC = 2'b10,
    TCMD_START = 2'b11
  } timer_cmd_e;

  typedef enum logic [1:0] {
    third_port_all_input = 2'b00,
    third_port_ctrl_output = 2'b01,
    third_port_ctrl_only = 2'b10,
    third_port_all_output = 2'b11
  } third_port_mode_e;

  typedef enum logic [1:0] {
    TMODE_LOW_SECOND_HALF = 2'b00,
    TMODE_SQUARE_WAVE = 2'b01,
    TMODE_SINGLE_PULSE = 2'b10,
    TMODE_PULSE_RESTART = 2'b11
  } timer_mode_e;

  typedef enum logic [1:0] {
    TST_IDLE = 2'b01,
    TST_RUN = 2'b10
  } timer_state_e;

endpackage

/* File: inc/timer_if.sv */
// Interface carrying commands and status between the port block and its timer.
`timescale 1ns/1ps
interface timer_if;
  logic start;
  logic stop_now;
  logic stop_after_tc;
  logic [13:0] length;
  logic [1:0] mode;
  logic running;
  logic terminal_count;
  logic timer_out;

  modport ctl (
    output start, stop_now, stop_after_tc, length, mode,
    input running, terminal_count, timer_out
  );
  modport tmr (
    input start, stop_now, stop_after_tc, length, mode,
    output running, terminal_count, timer_out
  );
endinterface

/* File: hdl/port_timer.sv */
// Fourteen-bit down counter with four output modes, driven by the port block.
`timescale 1ns/1ps
module port_timer (
  // Clock, reset and count enable
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_tick,
  // Command and status carrier
  timer_if.tmr tif
);

  io_ports_pkg::timer_state_e state;
  logic [13:0] count;
  logic [13:0] cur_length;
  logic [1:0] cur_mode;
  logic [13:0] pend_length;
  logic [1:0] pend_mode;
  logic pend_load;
  logic pend_stop;
  logic at_tc;
  logic single_shot;

  assign at_tc = (state == io_ports_pkg::TST_RUN) && i_tick && (count <= 14'd1);
  assign single_shot = (cur_mode == io_ports_pkg::TMODE_LOW_SECOND_HALF) ||
                       (cur_mode == io_ports_pkg::TMODE_SINGLE_PULSE);

  // Counting, loading and stopping. A start while running is parked until the
  // present terminal count so the running period is never cut short.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state <= io_ports_pkg::TST_IDLE;
      count <= io_ports_pkg::TIMER_LENGTH_RESET;
      cur_length <= io_ports_pkg::TIMER_LENGTH_RESET;
      cur_mode <= 2'b00;
      pend_length <= io_ports_pkg::TIMER_LENGTH_RESET;
      pend_mode <= 2'b00;
      pend_load <= 1'b0;
      pend_stop <= 1'b0;
    end else begin
      case (state)
        io_ports_pkg::TST_IDLE: begin
          pend_load <= 1'b0;
          pend_stop <= 1'b0;
          if (tif.start) begin
            cur_length <= tif.length;
            cur_mode <= tif.mode;
            count <= tif.length;
            state <= io_ports_pkg::TST_RUN;
          end
        end
        io_ports_pkg::TST_RUN: begin
          if (tif.start) begin
            pend_load <= 1'b1;
            pend_length <= tif.length;
            pend_mode <= tif.mode;
          end
          if (tif.stop_after_tc) begin
            pend_stop <= 1'b1;
          end
          if (tif.stop_now) begin
            state <= io_ports_pkg::TST_IDLE;
          end else if (at_tc) begin
            if (pend_load) begin
              cur_length <= pend_length;
              cur_mode <= pend_mode;
              count <= pend_length;
              pend_load <= 1'b0;
            end else if (pend_stop || single_shot) begin
              state <= io_ports_pkg::TST_IDLE;
            end else begin
              count <= cur_length;
            end
          end else if (i_tick) begin
            count <= count - 14'd1;
          end
        end
        default: begin
          state <= io_ports_pkg::TST_IDLE;
        end
      endcase
    end
  end

  // Output waveform: half-period modes are high in the first half, pulse modes
  // drop low at terminal count until the next tick, or one clock if the timer then stops; the output idles high.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      tif.timer_out <= 1'b1;
    end else if (state != io_ports_pkg::TST_RUN) begin
      tif.timer_out <= 1'b1;
    end else if (cur_mode[1]) begin
      if (at_tc) begin
        tif.timer_out <= 1'b0;
      end else if (i_tick) begin
        tif.timer_out <= 1'b1;
      end
    end else begin
      tif.timer_out <= (count > {1'b0, cur_length[13:1]});
    end
  end

  // Status back to the port block.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      tif.running <= 1'b0;
      tif.terminal_count <= 1'b0;
    end else begin
      tif.running <= (state == io_ports_pkg::TST_RUN);
      tif.terminal_count <= at_tc;
    end
  end

endmodule

/* File: hdl/ctrl_io_ports_timer.sv */
// Processor-facing LED latch, parallel ports and timer of the disk controller.
`timescale 1ns/1ps

// Overview of operation
// - LED n turns on at 20h+2n and off at 21h+2n.
// - LED latch acts on address only; reads and writes both count, data ignored.
// - Reset clears the LED latch, lighting all eight LEDs.
// - LED latch is write-only and never drops the ready line.
// - Command bit 0 sets switch port direction, bit 1 unit port direction.
// - Command bits 3-2 pick third-port mode: input, control-output, control, output.
// - Command bits 4 and 5 enable interrupts of the first and second ports.
// - Timer command 00 does nothing; 01 stops a running timer at once.
// - Timer command 11 starts now if idle, else after the present terminal count.
// - Status bits 0-2 and 3-5 give request, buffer flag, enable per port.
// - Status bit 6 latches at terminal count; clears on status read or start.
// - Switch port is input unless command bit 0 is set; bit 0 is the leftmost switch, bit 7 rightmost.
// - Unit port bits 0-3 drive activity LEDs, bits 4-7 unit selects.
// - Drive-control bit 0 picks write current: 0 outer tracks, 1 inner.
// - Drive bits 1, 2, 3 gate writing, head load and step direction.
// - Drive bit 5 resets the sequencer when 0; bit 4 reserved side select.
// - Timer high register holds count bits 13-8 and the mode in 7-6.
// - Mode 00 half low, 01 square, 10 single pulse, 11 pulse and restart.
// - Register at 05h holds the low eight bits of the count length.
// - Port selects decode only during I/O cycles, never in memory cycles.
module ctrl_io_ports_timer (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Local processor bus
  input wire logic i_io_cycle,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_ready,
  // Indicator LEDs, one means dark
  output logic [7:0] o_indicator_off,
  // Option switch port
  input wire logic [7:0] i_option_switch,
  output logic [7:0] o_switch_port_out,
  output logic o_switch_port_oe_n,
  // Unit select and activity LED port
  input wire logic [7:0] i_unit_port_in,
  output logic [3:0] o_activity_led,
  output logic [3:0] o_unit_select,
  output logic o_unit_port_oe_n,
  // Drive control port
  input wire logic [5:0] i_drive_port_in,
  output logic o_write_current_sel,
  output logic o_master_write_gate,
  output logic o_head_load_ctl,
  output logic o_step_direction,
  output logic o_side_select,
  output logic o_rw_sequencer_reset,
  output logic o_drive_port_oe_n,
  // Timer
  output logic o_timer_out,
  output logic o_terminal_count
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic access;
  logic led_hit;
  logic port_hit;
  logic wr_hit;
  logic rd_hit;
  logic [2:0] reg_sel;

  // Only I/O cycles select anything here, so memory accesses at the same low
  // address bits never disturb the ports or the LEDs.
  assign access = i_io_cycle && (i_rd || i_wr);
  assign led_hit = access && (i_addr >= io_ports_pkg::LED_ADDR_FIRST) &&
                   (i_addr <= io_ports_pkg::LED_ADDR_LAST);
  assign port_hit = (i_addr <= io_ports_pkg::OFS_TIMER_LOW_COUNT);
  assign wr_hit = i_io_cycle && i_wr && port_hit;
  assign rd_hit = i_io_cycle && i_rd && port_hit;
  assign reg_sel = i_addr[2:0];

  // ----------------------------------------------------------------
  // LED latch
  // ----------------------------------------------------------------
  // Address bit 0 is the sense, bits 3-1 pick the LED; bus data plays no part.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_indicator_off <= io_ports_pkg::LED_LATCH_RESET;
    end else if (led_hit) begin
      o_indicator_off[i_addr[3:1]] <= i_addr[0];
    end
  end

  // The ready line stays high; no access here ever inserts a wait state.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_ready <= 1'b1;
    end else begin
      o_ready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Command register
  // ----------------------------------------------------------------
  logic dir_a;
  logic dir_b;
  io_ports_pkg::third_port_mode_e third_mode;
  logic ien_a;
  logic ien_b;
  logic cmd_wr;

  assign cmd_wr = wr_hit && (i_addr == io_ports_pkg::OFS_COMMAND_STATUS);

  // Direction, third-port mode and interrupt enables are stored; the timer
  // field is a one-shot command and is not kept.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      dir_a <= 1'b0;
      dir_b <= 1'b0;
      third_mode <= io_ports_pkg::third_port_all_input;
      ien_a <= 1'b0;
      ien_b <= 1'b0;
    end else if (cmd_wr) begin
      dir_a <= i_wdata[io_ports_pkg::CMD_DIR_A_BIT];
      dir_b <= i_wdata[io_ports_pkg::CMD_DIR_B_BIT];
      third_mode <= io_ports_pkg::third_port_mode_e'(
                    i_wdata[io_ports_pkg::CMD_DRIVE_CONTROL_PORT_LSB +: 2]);
      ien_a <= i_wdata[io_ports_pkg::CMD_IEN_A_BIT];
      ien_b <= i_wdata[io_ports_pkg::CMD_IEN_B_BIT];
    end
  end

  // Output enables are registered copies of the direction settings so the
  // pin drivers never glitch on a decode.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_switch_port_oe_n <= 1'b1;
      o_unit_port_oe_n <= 1'b1;
      o_drive_port_oe_n <= 1'b1;
    end else begin
      o_switch_port_oe_n <= !dir_a;
      o_unit_port_oe_n <= !dir_b;
      o_drive_port_oe_n <= !((third_mode == io_ports_pkg::third_port_all_output) ||
                             (third_mode == io_ports_pkg::third_port_ctrl_output));
    end
  end

  // ----------------------------------------------------------------
  // Port latches
  // ----------------------------------------------------------------
  logic [7:0] unit_latch;
  logic [7:0] drive_latch;

  // Writes land in the latches whatever the direction, so software can
  // preset a value before turning a port to output.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_switch_port_out <= io_ports_pkg::PORT_RESET;
      unit_latch <= io_ports_pkg::PORT_RESET;
      drive_latch <= io_ports_pkg::PORT_RESET;
    end else if (wr_hit) begin
      case (i_addr)
        io_ports_pkg::OFS_OPTION_SWITCH_INPUT: begin
          o_switch_port_out <= i_wdata;
        end
        io_ports_pkg::OFS_UNIT_SELECT_LED_PORT: begin
          unit_latch <= i_wdata;
        end
        io_ports_pkg::OFS_DRIVE_CONTROL_PORT: begin
          drive_latch <= i_wdata & io_ports_pkg::DRV_IMPL_MASK;
        end
        default: begin
        end
      endcase
    end
  end

  // Unit port split: low nibble activity LEDs, high nibble unit selects.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_activity_led <= 4'h0;
      o_unit_select <= 4'h0;
    end else begin
      o_activity_led <= unit_latch[3:0];
      o_unit_select <= unit_latch[7:4];
    end
  end

  // Drive control lines, each a named bit of the drive latch.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_write_current_sel <= 1'b0;
      o_master_write_gate <= 1'b0;
      o_head_load_ctl <= 1'b0;
      o_step_direction <= 1'b0;
      o_side_select <= 1'b0;
      o_rw_sequencer_reset <= 1'b0;
    end else begin
      o_write_current_sel <= drive_latch[io_ports_pkg::DRV_WRITE_CURRENT_BIT];
      o_master_write_gate <= drive_latch[io_ports_pkg::DRV_MASTER_WRITE_GATE_BIT];
      o_head_load_ctl <= drive_latch[io_ports_pkg::DRV_HEAD_LOAD_CTL_BIT];
      o_step_direction <= drive_latch[io_ports_pkg::DRV_STEP_DIRECTION_BIT];
      o_side_select <= drive_latch[io_ports_pkg::DRV_SIDE_SELECT_BIT];
      o_rw_sequencer_reset <= drive_latch[io_ports_pkg::DRV_RW_SEQUENCER_RESET_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Buffer flags
  // ----------------------------------------------------------------
  logic buf_a;
  logic buf_b;

  // Without strobe handshake lines, a port's buffer flag marks data written
  // by the processor and not yet read back; a write in the same cycle as a
  // read leaves it set.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      buf_a <= 1'b0;
      buf_b <= 1'b0;
    end else begin
      if (wr_hit && (i_addr == io_ports_pkg::OFS_OPTION_SWITCH_INPUT)) begin
        buf_a <= 1'b1;
      end else if (rd_hit && (i_addr == io_ports_pkg::OFS_OPTION_SWITCH_INPUT)) begin
        buf_a <= 1'b0;
      end
      if (wr_hit && (i_addr == io_ports_pkg::OFS_UNIT_SELECT_LED_PORT)) begin
        buf_b <= 1'b1;
      end else if (rd_hit && (i_addr == io_ports_pkg::OFS_UNIT_SELECT_LED_PORT)) begin
        buf_b <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Timer registers and commands
  // ----------------------------------------------------------------
  logic [13:0] timer_length;
  logic [1:0] timer_mode;
  logic [1:0] timer_cmd;
  logic timer_flag;
  logic [3:0] tick_div;
  logic tick;
  timer_if tif ();

  // Count length and mode are plain read/write storage; the timer only takes
  // them when a start command arrives.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      timer_length <= io_ports_pkg::TIMER_LENGTH_RESET;
      timer_mode <= 2'b00;
    end else if (wr_hit && (i_addr == io_ports_pkg::OFS_TIMER_HIGH_MODE)) begin
      timer_length[13:8] <= i_wdata[io_ports_pkg::TMR_HIGH_COUNT_BITS-1:0];
      timer_mode <= i_wdata[io_ports_pkg::TMR_MODE_LSB +: 2];
    end else if (wr_hit && (i_addr == io_ports_pkg::OFS_TIMER_LOW_COUNT)) begin
      timer_length[7:0] <= i_wdata;
    end
  end

  // Decode the one-shot timer field of a command write.
  assign timer_cmd = cmd_wr ? i_wdata[io_ports_pkg::CMD_TIMER_LSB +: 2] : 2'b00;
  assign tif.start = (timer_cmd == io_ports_pkg::TCMD_START);
  assign tif.stop_now = (timer_cmd == io_ports_pkg::TCMD_STOP);
  assign tif.stop_after_tc = (timer_cmd == io_ports_pkg::TCMD_STOP_AFTER_TC);
  assign tif.length = timer_length;
  assign tif.mode = timer_mode;

  // Divider giving the timer its count enable, one pulse per sixteen clocks.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      tick_div <= 4'h0;
      tick <= 1'b0;
    end else begin
      tick <= (tick_div == io_ports_pkg::TIMER_TICK_LAST);
      tick_div <= tick_div + 4'h1;
    end
  end

  port_timer u_timer (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_tick(tick),
    .tif(tif)
  );

  // Terminal count flag: a count reaching terminal in the same cycle as the
  // status read stays set, so no event is lost.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      timer_flag <= 1'b0;
    end else if (tif.terminal_count) begin
      timer_flag <= 1'b1;
    end else if ((rd_hit && (i_addr == io_ports_pkg::OFS_COMMAND_STATUS)) || tif.start) begin
      timer_flag <= 1'b0;
    end
  end

  // Timer outputs, two register stages behind the counter.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_timer_out <= 1'b1;
      o_terminal_count <= 1'b0;
    end else begin
      o_timer_out <= tif.timer_out;
      o_terminal_count <= tif.terminal_count;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] next_rdata;
  logic [7:0] status;

  assign status = {1'b0, timer_flag, ien_b, buf_b, ien_b & buf_b,
                   ien_a, buf_a, ien_a & buf_a};

  // The LED latch has no readback, so its addresses return zero like any
  // unmapped address.
  always_comb begin
    next_rdata = 8'h00;
    if (rd_hit) begin
      case (reg_sel)
        io_ports_pkg::OFS_COMMAND_STATUS[2:0]: begin
          next_rdata = status;
        end
        io_ports_pkg::OFS_OPTION_SWITCH_INPUT[2:0]: begin
          next_rdata = dir_a ? o_switch_port_out : i_option_switch;
        end
        io_ports_pkg::OFS_UNIT_SELECT_LED_PORT[2:0]: begin
          next_rdata = dir_b ? unit_latch : i_unit_port_in;
        end
        io_ports_pkg::OFS_DRIVE_CONTROL_PORT[2:0]: begin
          if (third_mode == io_ports_pkg::third_port_all_input) begin
            next_rdata = {2'b00, i_drive_port_in};
          end else begin
            next_rdata = drive_latch & io_ports_pkg::DRV_IMPL_MASK;
          end
        end
        io_ports_pkg::OFS_TIMER_HIGH_MODE[2:0]: begin
          next_rdata = {timer_mode, timer_length[13:8]};
        end
        io_ports_pkg::OFS_TIMER_LOW_COUNT[2:0]: begin
          next_rdata = timer_length[7:0];
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  // Read data is registered and holds until the next I/O read.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_rdata <= 8'h00;
    end else if (i_io_cycle && i_rd) begin
      o_rdata <= next_rdata;
    end
  end

endmodule

/* File: tb/io_ports_chk_sva.sv */
// Checker of the bus and pin behaviour of the I/O port block.
`timescale 1ns/1ps
module io_ports_chk (
  // Bus and pins watched
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_io_cycle,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] i_option_switch,
  input wire logic [7:0] o_rdata,
  input wire logic o_ready,
  input wire logic [7:0] o_indicator_off,
  input wire logic o_switch_port_oe_n,
  input wire logic o_drive_port_oe_n
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  // Steps of an access: a taken I/O strobe and, in the same cycle, the decoded target.
  sequence io_acc;
    i_io_cycle && (i_rd || i_wr);
  endsequence
  sequence led_acc;
    io_acc ##0 (i_addr[7:4] == 4'h2);
  endsequence
  sequence cmd_wr;
    io_acc ##0 (i_wr && i_addr == 8'h00);
  endsequence
  a_ready_high: assert property (o_ready)
    else $error("ready line dropped");
  a_led_sense: assert property (led_acc |=>
    o_indicator_off[$past(i_addr[3:1])] == $past(i_addr[0]))
    else $error("indicator bit does not follow address sense");
  a_led_others_kept: assert property (led_acc |=>
    ((o_indicator_off ^ $past(o_indicator_off)) & ~(8'h01 << $past(i_addr[3:1]))) == 8'h00)
    else $error("indicator access changed another bit");
  a_led_reset_lit: assert property ($rose(i_rstn) |-> o_indicator_off == 8'h00)
    else $error("indicators not all lit after reset");
  a_mem_ignored: assert property ((!i_io_cycle && (i_rd || i_wr)) |=>
    $stable(o_indicator_off))
    else $error("memory cycle reached the indicator latch");
  a_switch_dir: assert property (cmd_wr |=> ##1 o_switch_port_oe_n == !$past(i_wdata[0], 2))
    else $error("switch port direction wrong");
  a_drive_mode: assert property (cmd_wr |=> ##1 o_drive_port_oe_n == !$past(i_wdata[2], 2))
    else $error("drive port enable wrong for mode");
  a_switch_read: assert property (io_acc ##0 (i_rd && i_addr == 8'h01) |=>
    o_rdata == $past(i_option_switch))
    else $error("switch read data wrong");
  a_led_no_read: assert property (led_acc ##0 i_rd |=> o_rdata == 8'h00)
    else $error("indicator latch read back");
endmodule
bind ctrl_io_ports_timer io_ports_chk chk (.*);

/* File: tb/host_model.sv */
// Host processor model issuing I/O and memory cycles to the port block.
`timescale 1ns/1ps
module host_model (
  // Bus toward the block
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic o_io_cycle,
  output logic o_rd,
  output logic o_wr,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  // Idle bus at time zero.
  initial begin
    o_io_cycle = 1'b1;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_addr = 8'hff;
    o_wdata = 8'h00;
  end
  // One access held through its taking edge; then strobes drop and address and data show the inverse value.
  task automatic acc(input logic io, input logic rd, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge i_clk);
    o_io_cycle <= io;
    o_rd <= rd;
    o_wr <= !rd;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
    #1 q = i_rdata;
  endtask
endmodule

/* File: tb/ctrl_io_ports_timer_tb.sv */
// Self-checking bench of the I/O port block driven by the host model.
`timescale 1ns/1ps
module ctrl_io_ports_timer_tb;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_io_cycle, i_rd, i_wr, o_ready, o_switch_port_oe_n, o_unit_port_oe_n;
  logic o_write_current_sel, o_master_write_gate, o_head_load_ctl, o_step_direction;
  logic o_side_select, o_rw_sequencer_reset, o_drive_port_oe_n, o_timer_out, o_terminal_count;
  logic [7:0] i_addr, i_wdata, i_option_switch, i_unit_port_in, o_rdata, o_indicator_off, q;
  logic [7:0] o_switch_port_out;
  logic [5:0] i_drive_port_in;
  logic [3:0] o_activity_led, o_unit_select;
  int failures = 0;
  int checks_done = 0;
  int tc_seen = 0;
  int base;
  always #2.5 i_clk = ~i_clk;
  ctrl_io_ports_timer dut (.*);
  host_model host (.i_clk(i_clk), .i_rdata(o_rdata), .o_io_cycle(i_io_cycle), .o_rd(i_rd),
                   .o_wr(i_wr), .o_addr(i_addr), .o_wdata(i_wdata));
  // Counts terminal-count pulses; the pulse stands one cycle so each edge sees it once.
  always @(posedge i_clk) begin
    if (o_terminal_count === 1'b1) tc_seen <= tc_seen + 1;
  end
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.acc(1'b1, 1'b0, a, d, q);
  endtask
  task automatic tc_after(input int cycles, input logic [7:0] exp);
    base = tc_seen;
    repeat (cycles) @(posedge i_clk);
    cmp8(8'(tc_seen - base), exp);
  endtask
  task automatic final_report();
    if (failures == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog well beyond the roughly thirteen hundred cycles the sequence needs.
  initial begin
    repeat (20000) @(posedge i_clk);
    failures++;
    final_report();
  end
  // Main sequence.
  initial begin
    i_option_switch <= 8'h96;
    i_unit_port_in <= 8'h00;
    i_drive_port_in <= 6'h00;
    repeat (20) @(posedge i_clk);
    cmp8(o_indicator_off, 8'h00);
    cmp8({4'h0, o_ready, o_switch_port_oe_n, o_drive_port_oe_n, o_timer_out}, 8'h0f);
    i_rstn <= 1'b1;
    for (int n = 0; n < 8; n++) begin
      host.acc(1'b1, 1'b1, 8'h21 + 8'(2 * n), 8'h00, q);
      cmp8(o_indicator_off, 8'hff >> (7 - n));
    end
    host.acc(1'b0, 1'b0, 8'h24, 8'h00, q);
    cmp8(o_indicator_off, 8'hff);
    wr(8'h24, 8'hff);
    cmp8(o_indicator_off, 8'hfb);
    host.acc(1'b1, 1'b1, 8'h2e, 8'h00, q);
    cmp8(q, 8'h00);
    cmp8(o_indicator_off, 8'h7b);
    host.acc(1'b1, 1'b1, 8'h01, 8'h00, q);
    cmp8(q, 8'h96);
    wr(8'h00, 8'h3e);
    wr(8'h02, 8'ha5);
    wr(8'h03, 8'hff);
    @(posedge i_clk);
    #1 cmp8({o_unit_select, o_activity_led}, 8'ha5);
    cmp8({2'b00, o_rw_sequencer_reset, o_side_select, o_step_direction, o_head_load_ctl,
          o_master_write_gate, o_write_current_sel}, 8'h3f);
    cmp8({5'h00, o_switch_port_oe_n, o_unit_port_oe_n, o_drive_port_oe_n}, 8'h04);
    cmp8(o_switch_port_out, 8'h00);
    host.acc(1'b1, 1'b1, 8'h03, 8'h00, q);
    cmp8(q, 8'h3f);
    wr(8'h04, 8'h80);
    wr(8'h05, 8'h04);
    host.acc(1'b1, 1'b1, 8'h04, 8'h00, q);
    cmp8(q, 8'h80);
    host.acc(1'b1, 1'b1, 8'h05, 8'h00, q);
    cmp8(q, 8'h04);
    host.acc(1'b1, 1'b1, 8'h00, 8'h00, q);
    cmp8(q, 8'h3c);
    wr(8'h00, 8'hfe);
    tc_after(300, 8'h01);
    host.acc(1'b1, 1'b1, 8'h00, 8'h00, q);
    cmp8(q & 8'h40, 8'h40);
    host.acc(1'b1, 1'b1, 8'h00, 8'h00, q);
    cmp8(q & 8'h40, 8'h00);
    wr(8'h04, 8'hc0);
    wr(8'h00, 8'hfe);
    wr(8'h00, 8'h7e);
    tc_after(300, 8'h00);
    wr(8'h00, 8'hfe);
    wr(8'h00, 8'hbe);
    tc_after(300, 8'h01);
    // A start while running must wait for the present terminal count.
    wr(8'h00, 8'hfe);
    wr(8'h04, 8'h80);
    wr(8'h05, 8'h08);
    wr(8'h00, 8'hfe);
    tc_after(300, 8'h02);
    wr(8'h00, 8'hfe);
    host.acc(1'b1, 1'b1, 8'h00, 8'h00, q);
    cmp8(q & 8'h40, 8'h00);
    final_report();
  end
endmodule
